// >>> hmap_chk.sv
// concurrent checks on the link between host and device ends
module hmap_chk (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic port_select_n,
  input wire logic address_latch_strobe,
  input wire logic host_write_strobe_n,
  input wire logic host_read_strobe_n,
  input wire logic transfer_acknowledge_n,
  input wire logic bus_dev_oe,
  input wire logic [15:0] shared_addr_data_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_on;
  logic rd_on;
  logic al_on;
  assign wr_on = !port_select_n && !host_write_strobe_n;
  assign rd_on = !port_select_n && !host_read_strobe_n;
  assign al_on = !port_select_n && address_latch_strobe;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // acknowledge line high means busy, low means free
  latch_when_free_a: assert property ($rose(al_on) |-> !transfer_acknowledge_n)
    else $error("latch phase opened while port busy");
  latch_addr_hold_a: assert property ($fell(al_on) |-> $stable(shared_addr_data_bus))
    else $error("address moved as latch phase closed");
  phase_overlap_a: assert property (!(al_on && (wr_on || rd_on)))
    else $error("strobe overlaps latch phase");
  wr_when_free_a: assert property ($rose(wr_on) |-> !$past(transfer_acknowledge_n))
    else $error("write started while port busy");
  wr_busy_a: assert property ($rose(wr_on) |=> transfer_acknowledge_n)
    else $error("no busy after write start");
  // early strobe end lets the port free up sooner
  long_wr_hold_a: assert property ($rose(wr_on) |=> (transfer_acknowledge_n || !wr_on) [*2])
    else $error("long write freed too early");
  rd_busy_a: assert property ($rose(rd_on) |=> transfer_acknowledge_n)
    else $error("no busy after read start");
  rd_min_hold_a: assert property ($rose(rd_on) |=> rd_on)
    else $error("read strobe too short");
  rd_drive_a: assert property ($rose(rd_on) |=> bus_dev_oe)
    else $error("previous word not driven at read start");
  bus_release_a: assert property ($fell(rd_on) |=> !bus_dev_oe)
    else $error("bus still driven after read end");
  rd_hold_a: assert property ($fell(transfer_acknowledge_n) && rd_on |=> rd_on)
    else $error("read released too soon after port free");
  cover property ($rose(al_on));
  cover property ($rose(wr_on));
  cover property ($rose(rd_on));
  // one busy cycle only: second half of a program word
  cover property ($rose(rd_on) ##1 transfer_acknowledge_n ##1 !transfer_acknowledge_n);
endmodule : hmap_chk

// >>> hmap_device.sv
// device end: memory behind the host port with overlay control register
`include "hmap_params.svh"
module hmap_device (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  hmap_if.dev LINK,
  output logic SHORT_READ_ONLY_O,
  output logic [15:0] LAST_ADDR_O
);
  import hmap_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_WR, S_RD, S_DONE} hmap_dstate_e;
  typedef struct packed {
    hmap_dstate_e st;
    logic [15:0] addr;
    logic pm_half;
    logic [15:0] ovl;
    logic [15:0] prev;
    logic [15:0] wdata;
    logic [1:0] cnt;
    logic busy;
    logic oe;
    logic [15:0] dout;
    logic in_latch;
    logic [(`HMAP_MEM_DEPTH*16)-1:0] mem;
  } hmap_dev_s;
  hmap_dev_s q_r, q_nxt;
  function automatic logic [`HMAP_IDX_W-1:0] idx(input logic [15:0] a);
    idx = a[`HMAP_IDX_W-1:0];
  endfunction : idx
  function automatic logic is_ovl(input logic [15:0] a);
    is_ovl = (a == `HMAP_OVL_ADDR);
  endfunction : is_ovl
  function automatic logic [15:0] step_addr(input logic [15:0] a);
    step_addr = a + 16'h0001;
  endfunction : step_addr
  function automatic logic [1:0] bump(input logic [1:0] c);
    bump = c + 2'd1;
  endfunction : bump
  logic latch_on, wr_on, rd_on;
  assign latch_on = !LINK.port_select_n && LINK.address_latch_strobe;
  assign wr_on = !LINK.port_select_n && !LINK.host_write_strobe_n;
  assign rd_on = !LINK.port_select_n && !LINK.host_read_strobe_n;
  always_comb begin
    q_nxt = q_r;
    q_nxt.in_latch = latch_on;
    if (q_r.in_latch && !latch_on) begin
      q_nxt.addr = LINK.shared_addr_data_bus;
      q_nxt.pm_half = 1'b0;
    end
    unique case (q_r.st)
      S_IDLE: begin
        q_nxt.cnt = 2'd0;
        if (wr_on) begin
          q_nxt.st = S_WR;
          q_nxt.busy = 1'b1;
          q_nxt.wdata = LINK.shared_addr_data_bus;
        end else if (rd_on) begin
          q_nxt.st = S_RD;
          q_nxt.busy = 1'b1;
          q_nxt.oe = 1'b1;
          q_nxt.dout = q_r.prev;
        end
      end
      S_WR: begin
        if (wr_on) q_nxt.wdata = LINK.shared_addr_data_bus;
        q_nxt.cnt = bump(q_r.cnt);
        // while the strobe is held, ack falls no sooner than 1.5 processor cycles, rounded to clocks
        if (!wr_on || bump(q_r.cnt) >= 2'(`HMAP_LONG_WR_CYC)) begin
          if (is_ovl(q_r.addr)) q_nxt.ovl = q_nxt.wdata;
          else q_nxt.mem[idx(q_r.addr)*16 +: 16] = q_nxt.wdata;
          q_nxt.addr = step_addr(q_r.addr);
          q_nxt.busy = 1'b0;
          q_nxt.st = wr_on ? S_DONE : S_IDLE;
        end
      end
      S_RD: begin
        q_nxt.cnt = bump(q_r.cnt);
        if (!rd_on) begin
          q_nxt.oe = 1'b0;
        end
        // program half two holds previous data one cycle, others two
        if (bump(q_r.cnt) >= (q_r.pm_half ? 2'(`HMAP_RD_HOLD_SECOND)
            : 2'(`HMAP_RD_HOLD_FIRST)) || !rd_on) begin
          q_nxt.prev = is_ovl(q_r.addr) ? q_r.ovl : q_r.mem[idx(q_r.addr)*16 +: 16];
          if (!q_r.ovl[`HMAP_SRO_BIT] && rd_on) q_nxt.dout = q_nxt.prev;
          if (q_r.addr[`HMAP_SPACE_BIT] && !q_r.pm_half) q_nxt.pm_half = 1'b1;
          else begin
            q_nxt.pm_half = 1'b0;
            q_nxt.addr = step_addr(q_r.addr);
          end
          q_nxt.busy = 1'b0;
          q_nxt.st = rd_on ? S_DONE : S_IDLE;
        end
      end
      S_DONE: begin
        if (!wr_on && !rd_on) begin
          q_nxt.oe = 1'b0;
          q_nxt.st = S_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      q_r <= '0;
      q_r.st <= S_IDLE;
      q_r.ovl <= `HMAP_OVL_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end
  // line high while busy, low when the port is free
  assign LINK.transfer_acknowledge_n = q_r.busy;
  assign LINK.bus_dev_o = q_r.dout;
  assign LINK.bus_dev_oe = q_r.oe;
  assign SHORT_READ_ONLY_O = q_r.ovl[`HMAP_SRO_BIT];
  assign LAST_ADDR_O = q_r.addr;
endmodule : hmap_device

// >>> hmap_host.sv
// host end: drives latch, write and read sequences on the port
`include "hmap_params.svh"
module hmap_host (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  hmap_if.host LINK,
  input wire hmap_pkg::hmap_cmd_e CMD_I,
  input wire logic CMD_VALID_I,
  input wire logic [15:0] CMD_ADDR_I,
  input wire logic [15:0] CMD_DATA_I,
  output logic CMD_READY_O,
  output logic RD_VALID_O,
  output logic [15:0] RD_DATA_O
);
  import hmap_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_LATCH, H_GAP, H_STROBE, H_WAIT, H_HOLD} hmap_hstate_e;
  typedef struct packed {
    hmap_hstate_e st;
    hmap_cmd_e cmd;
    logic [15:0] addr;
    logic [15:0] data;
    logic [1:0] cnt;
    logic sel_n, ale, wr_n, rd_n, oe;
    logic [15:0] dout;
    logic ready, rvalid;
    logic [15:0] rdata;
    logic seen_busy;
    logic half;
    logic addr_ok;
  } hmap_host_s;
  hmap_host_s q_r, q_nxt;
  function automatic logic [1:0] bump(input logic [1:0] c);
    bump = c + 2'd1;
  endfunction : bump
  logic ack_low;
  // acknowledge low means the port is free
  assign ack_low = !LINK.transfer_acknowledge_n;
  always_comb begin
    q_nxt = q_r;
    q_nxt.rvalid = 1'b0;
    unique case (q_r.st)
      H_IDLE: if (CMD_VALID_I && CMD_I != HMAP_NONE && ack_low) begin
        q_nxt.cmd = CMD_I;
        q_nxt.data = CMD_DATA_I;
        q_nxt.ready = 1'b0;
        q_nxt.cnt = 2'd0;
        // port already points there: skip the latch, else a program
        // word's second half could never be reached
        if (q_r.addr_ok && CMD_ADDR_I == q_r.addr) begin
          q_nxt.st = H_GAP;
        end else begin
          q_nxt.addr = CMD_ADDR_I;
          q_nxt.half = 1'b0;
          q_nxt.addr_ok = 1'b1;
          q_nxt.sel_n = 1'b0;
          q_nxt.ale = 1'b1;
          q_nxt.oe = 1'b1;
          q_nxt.dout = CMD_ADDR_I;
          q_nxt.st = H_LATCH;
        end
      end
      H_LATCH: begin
        q_nxt.ale = 1'b0;
        q_nxt.sel_n = 1'b1;
        q_nxt.st = H_GAP;
      end
      H_GAP: if (ack_low) begin
        q_nxt.sel_n = 1'b0;
        q_nxt.seen_busy = 1'b0;
        q_nxt.cnt = 2'd0;
        if (q_r.cmd == HMAP_WR) begin
          q_nxt.wr_n = 1'b0;
          q_nxt.oe = 1'b1;
          q_nxt.dout = q_r.data;
        end else begin
          q_nxt.rd_n = 1'b0;
          q_nxt.oe = 1'b0;
        end
        q_nxt.st = H_STROBE;
      end
      H_STROBE: begin
        q_nxt.cnt = bump(q_r.cnt);
        if (bump(q_r.cnt) >= 2'(`HMAP_STROBE_CYC)) q_nxt.st = H_WAIT;
      end
      H_WAIT: begin
        if (!ack_low) q_nxt.seen_busy = 1'b1;
        if (q_r.seen_busy && ack_low) begin
          q_nxt.cnt = 2'd0;
          q_nxt.st = H_HOLD;
        end
      end
      H_HOLD: begin
        q_nxt.cnt = bump(q_r.cnt);
        // strobe stays past the ack fall to cover read sampling
        if (bump(q_r.cnt) >= 2'(`HMAP_ACK_HOLD_CYC)) begin
          if (q_r.cmd == HMAP_RD) begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rdata = LINK.shared_addr_data_bus;
          end
          // mirror the port's own address step to know when a latch is needed
          if (q_r.cmd == HMAP_RD && q_r.addr[`HMAP_SPACE_BIT] && !q_r.half) begin
            q_nxt.half = 1'b1;
          end else begin
            if (q_r.cmd == HMAP_RD) q_nxt.half = 1'b0;
            q_nxt.addr = q_r.addr + 16'h0001;
          end
          q_nxt.sel_n = 1'b1;
          q_nxt.wr_n = 1'b1;
          q_nxt.rd_n = 1'b1;
          q_nxt.oe = 1'b0;
          q_nxt.ready = 1'b1;
          q_nxt.st = H_IDLE;
        end
      end
      default: q_nxt.st = H_IDLE;
    endcase
  end
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      q_r <= '0;
      q_r.st <= H_IDLE;
      q_r.cmd <= HMAP_NONE;
      q_r.sel_n <= 1'b1;
      q_r.wr_n <= 1'b1;
      q_r.rd_n <= 1'b1;
      q_r.ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign LINK.port_select_n = q_r.sel_n;
  assign LINK.address_latch_strobe = q_r.ale;
  assign LINK.host_write_strobe_n = q_r.wr_n;
  assign LINK.host_read_strobe_n = q_r.rd_n;
  assign LINK.bus_host_o = q_r.dout;
  assign LINK.bus_host_oe = q_r.oe;
  assign CMD_READY_O = q_r.ready;
  assign RD_VALID_O = q_r.rvalid;
  assign RD_DATA_O = q_r.rdata;
endmodule : hmap_host

// >>> hmap_if.sv
// link between host and device ends of the port
interface hmap_if;
  logic port_select_n;
  logic address_latch_strobe;
  logic host_write_strobe_n;
  logic host_read_strobe_n;
  logic transfer_acknowledge_n;
  logic [15:0] bus_host_o;
  logic bus_host_oe;
  logic [15:0] bus_dev_o;
  logic bus_dev_oe;
  logic [15:0] shared_addr_data_bus;
  assign shared_addr_data_bus = bus_dev_oe ? bus_dev_o : (bus_host_oe ? bus_host_o : 16'h0000);
  modport dev (input port_select_n, address_latch_strobe, host_write_strobe_n,
    host_read_strobe_n, shared_addr_data_bus, output transfer_acknowledge_n, bus_dev_o,
    bus_dev_oe);
  modport host (output port_select_n, address_latch_strobe, host_write_strobe_n,
    host_read_strobe_n, bus_host_o, bus_host_oe, input transfer_acknowledge_n,
    shared_addr_data_bus);
endinterface : hmap_if

// >>> hmap_params.svh
// constants for the host memory access port
`ifndef HMAP_PARAMS_SVH
`define HMAP_PARAMS_SVH
`define HMAP_CLK_PERIOD_NS 20
`define HMAP_LATCH_MIN_NS 10
`define HMAP_LATCH_CYC ((`HMAP_LATCH_MIN_NS + `HMAP_CLK_PERIOD_NS - 1) / `HMAP_CLK_PERIOD_NS)
`define HMAP_STROBE_MIN_NS 10
`define HMAP_STROBE_CYC ((`HMAP_STROBE_MIN_NS + `HMAP_CLK_PERIOD_NS - 1) / `HMAP_CLK_PERIOD_NS)
`define HMAP_ACK_HOLD_NS 10
`define HMAP_ACK_HOLD_CYC ((`HMAP_ACK_HOLD_NS + `HMAP_CLK_PERIOD_NS - 1) / `HMAP_CLK_PERIOD_NS)
`define HMAP_LONG_WR_CYC 2
`define HMAP_RD_HOLD_FIRST 2
`define HMAP_RD_HOLD_SECOND 1
`define HMAP_OVL_ADDR 16'h3fe7
`define HMAP_SRO_BIT 14
`define HMAP_OVL_RESET 16'h0000
`define HMAP_SPACE_BIT 15
`define HMAP_MEM_DEPTH 16
`define HMAP_IDX_W 4
`endif

// >>> hmap_pkg.sv
// types shared by both ends of the host memory access port
package hmap_pkg;
  typedef logic [15:0] hmap_word_t;
  typedef enum logic [1:0] {HMAP_NONE, HMAP_RD, HMAP_WR} hmap_cmd_e;
endpackage : hmap_pkg

// >>> hmap_tb_top.sv
// self-checking bench joining host and device ends
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module hmap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hmap_pkg::*;
  logic clk;
  logic rst;
  hmap_cmd_e cmd;
  logic cmd_valid;
  hmap_word_t cmd_addr;
  hmap_word_t cmd_data;
  logic cmd_ready;
  logic rd_valid;
  logic [15:0] rd_data;
  logic sro;
  logic [15:0] last_addr;
  int mismatches;
  int checked;
  hmap_if lnk ();
  hmap_host u_hmap_host (.CLOCK_I(clk), .RST_I(rst), .LINK(lnk.host), .CMD_I(cmd),
    .CMD_VALID_I(cmd_valid), .CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data),
    .CMD_READY_O(cmd_ready), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data));
  hmap_device u_hmap_device (.CLOCK_I(clk), .RST_I(rst), .LINK(lnk.dev),
    .SHORT_READ_ONLY_O(sro), .LAST_ADDR_O(last_addr));
  hmap_chk u_hmap_chk (.CLOCK_I(clk), .RST_I(rst), .port_select_n(lnk.port_select_n),
    .address_latch_strobe(lnk.address_latch_strobe),
    .host_write_strobe_n(lnk.host_write_strobe_n), .host_read_strobe_n(lnk.host_read_strobe_n),
    .transfer_acknowledge_n(lnk.transfer_acknowledge_n), .bus_dev_oe(lnk.bus_dev_oe),
    .shared_addr_data_bus(lnk.shared_addr_data_bus));

  task finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // one command, then wait for idle (and the read pulse) under a bound
  task xfer(input hmap_cmd_e k, input hmap_word_t a, input hmap_word_t d);
    int n;
    bit got;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    cmd <= k;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      if (rd_valid === 1'b1) got = 1'b1;
    end while (!(cmd_ready === 1'b1 && (k != HMAP_RD || got)) && n < 60);
    if (n >= 60) begin
      mismatches++;
      $display("[FAIL] transfer expected done seen timeout");
      finish_test();
    end
  endtask : xfer

  task t_reset;
    `CHK("short read mode", 1'b0, sro)
  endtask : t_reset

  task t_write_read;
    xfer(HMAP_WR, 16'h0003, 16'h1234);
    `CHK("addr after write", 16'h0004, last_addr)
    xfer(HMAP_WR, 16'h0004, 16'habcd);
    xfer(HMAP_RD, 16'h0003, 16'h0000);
    `CHK("read word", 16'h1234, rd_data)
    `CHK("addr after read", 16'h0004, last_addr)
    xfer(HMAP_RD, 16'h0004, 16'h0000);
    `CHK("next read word", 16'habcd, rd_data)
  endtask : t_write_read

  // memory is indexed by low bits, so 0x8003 shares word 3
  task t_program_half;
    xfer(HMAP_RD, 16'h8003, 16'h0000);
    `CHK("first half addr", 16'h8003, last_addr)
    `CHK("first half word", 16'h1234, rd_data)
    xfer(HMAP_RD, 16'h8003, 16'h0000);
    `CHK("second half word", 16'h1234, rd_data)
    `CHK("second half addr", 16'h8004, last_addr)
  endtask : t_program_half

  task t_short_read;
    xfer(HMAP_WR, 16'h3fe7, 16'h4000);
    `CHK("short read set", 1'b1, sro)
    xfer(HMAP_RD, 16'h0004, 16'h0000);
    `CHK("held word", 16'h1234, rd_data)
    xfer(HMAP_WR, 16'h3fe7, 16'h0000);
    `CHK("short read clear", 1'b0, sro)
  endtask : t_short_read

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    cmd = HMAP_NONE;
    cmd_valid = 1'b0;
    cmd_addr = 16'h0000;
    cmd_data = 16'h0000;
    mismatches = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_write_read();
    t_program_half();
    t_short_read();
    finish_test();
  end
endmodule : hmap_tb_top
